// ==== gdp_pkg.sv ====
/*
  gdp_pkg: constants and carrier types for the gate-driver protection block.
  assumes a 250 MHz system clock; all timing is derived from CLOCK_MHZ.
*/
package gdp_pkg;

  localparam int CLOCK_MHZ = 250;

  // times in ns, as printed; the long overcurrent hold in ms
  localparam int UV_FILTER_NS    = 3000;
  localparam int OC_BLANK_NS     = 500;
  localparam int OV_FILTER_NS    = 2000;
  localparam int OV_HOLD_NS      = 31000;
  localparam int OC_HOLD_SHORT_NS = 34000;
  localparam int OC_HOLD_LONG_MS = 8;
  localparam int SD_MIN_PULSE_NS = 3000;

  // least times round up
  localparam int UV_FILTER_CYC = (UV_FILTER_NS * CLOCK_MHZ + 999) / 1000;
  localparam int OC_BLANK_CYC  = (OC_BLANK_NS * CLOCK_MHZ + 999) / 1000;
  localparam int OV_FILTER_CYC = (OV_FILTER_NS * CLOCK_MHZ + 999) / 1000;
  localparam int OV_HOLD_CYC   = (OV_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int OC_HOLD_SHORT_CYC = (OC_HOLD_SHORT_NS * CLOCK_MHZ + 999) / 1000;
  localparam int OC_HOLD_LONG_CYC  = OC_HOLD_LONG_MS * CLOCK_MHZ * 1000;
  localparam int SD_MIN_PULSE_CYC  = (SD_MIN_PULSE_NS * CLOCK_MHZ + 999) / 1000;

  localparam int CNT_W = 24;
  localparam int PHASES = 3;

  // comparator flags, one bit per condition
  typedef struct packed {
    logic [PHASES-1:0] bootstrap_low;   // bootstrap supply at or below stop level
    logic              high_logic_low;  // high-side logic supply at or below stop level
    logic              low_logic_low;   // low-side logic supply at or below stop level
    logic              overcurrent;     // sense at or above overcurrent_threshold
    logic              bus_high;        // bus_voltage_sense at or above operate level
    logic              bus_released;    // bus_voltage_sense at or below release level
  } gdp_flags_s;

endpackage

// ==== gdp_protect.sv ====
/*
  gdp_protect: protection and fault logic of a three-phase gate driver.
  assumes comparator flags and commands arrive asynchronously on pins,
  and that the fault line is open-drain with an external pull-up.
  the comparators own their hysteresis; only their levels reach this block.
  a free-running clock gives every filter, blanking and hold time.
*/
// Function
// - bootstrap undervoltage forces that high-side gate low
// - high-side returns only on next command rising edge
// - no fault indication for high-side supply lockouts
// - bootstrap undervoltage shorter than filter ignored
// - high-logic undervoltage forces all high-side gates low
// - high-logic recovered: high commands pass straight through
// - high-logic undervoltage dips shorter than filter ignored
// - low-logic undervoltage forces all low-side gates low
// - low-logic recovered: low commands pass straight through
// - fault line low throughout low-logic lockout
// - low-logic undervoltage dips shorter than filter ignored
// - overcurrent declared after continuous blanking time
// - overcurrent: low-side gates off, fault line low
// - fault held full hold time after overcurrent
// - static select chooses short or long hold
// - overvoltage starts after continuous filter time
// - overvoltage: low-side gates off, fault line low
// - fault held hold time after bus release
// - any low fault line holds low-side off
// - fault line doubles as external shutdown input
`timescale 1ns/10ps
`default_nettype none
module gdp_protect #(
  parameter int OC_HOLD_LONG = gdp_pkg::OC_HOLD_LONG_CYC
) (
  input  wire logic                      CLOCK,
  input  wire logic                      RSTN,
  input  wire logic [gdp_pkg::PHASES-1:0] HIGH_SIDE_COMMAND,
  input  wire logic [gdp_pkg::PHASES-1:0] LOW_SIDE_COMMAND,
  input  wire gdp_pkg::gdp_flags_s       FLAGS,
  input  wire logic                      HOLD_SELECT_LONG,
  input  wire logic                      FAULT_LINE_IN,
  output logic                           FAULT_LINE_OUT,
  output logic                           FAULT_LINE_OE,
  output logic [gdp_pkg::PHASES-1:0]     HIGH_SIDE_GATE_OUT,
  output logic [gdp_pkg::PHASES-1:0]     LOW_SIDE_GATE_OUT
);

  localparam int W = gdp_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin input; only stage two is read
  logic [gdp_pkg::PHASES-1:0] hcmd_meta_reg;
  logic [gdp_pkg::PHASES-1:0] hcmd_reg;
  logic [gdp_pkg::PHASES-1:0] lcmd_meta_reg;
  logic [gdp_pkg::PHASES-1:0] lcmd_reg;
  gdp_pkg::gdp_flags_s        flags_meta_reg;
  gdp_pkg::gdp_flags_s        flags_reg;
  logic                       sel_meta_reg;
  logic                       sel_reg;
  logic                       line_meta_reg;
  logic                       line_reg;

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      hcmd_meta_reg  <= '0;
      hcmd_reg       <= '0;
      lcmd_meta_reg  <= '0;
      lcmd_reg       <= '0;
      flags_meta_reg <= '0;
      flags_reg      <= '0;
      sel_meta_reg   <= 1'b0;
      sel_reg        <= 1'b0;
      // released wire idles high; a low reset value would fake a shutdown
      line_meta_reg  <= 1'b1;
      line_reg       <= 1'b1;
    end else begin
      hcmd_meta_reg  <= HIGH_SIDE_COMMAND;
      hcmd_reg       <= hcmd_meta_reg;
      lcmd_meta_reg  <= LOW_SIDE_COMMAND;
      lcmd_reg       <= lcmd_meta_reg;
      flags_meta_reg <= FLAGS;
      flags_reg      <= flags_meta_reg;
      sel_meta_reg   <= HOLD_SELECT_LONG;
      sel_reg        <= sel_meta_reg;
      line_meta_reg  <= FAULT_LINE_IN;
      line_reg       <= line_meta_reg;
    end
  end

  logic [gdp_pkg::PHASES-1:0] hcmd;
  logic [gdp_pkg::PHASES-1:0] lcmd;
  gdp_pkg::gdp_flags_s        fl;
  logic                       sel_long;
  logic                       line_low;
  assign hcmd     = hcmd_reg;
  assign lcmd     = lcmd_reg;
  assign fl       = flags_reg;
  assign sel_long = sel_reg;
  assign line_low = ~line_reg;

  ////////////////////////////////////////////////////////////////////////
  // qualify filters: one per undervoltage flag and for overcurrent / bus
  localparam int NQ = gdp_pkg::PHASES + 4;
  logic [NQ-1:0] q_raw;
  logic [NQ-1:0] q_done;
  logic [W-1:0]  q_len [NQ];
  assign q_raw = {fl.bootstrap_low, fl.high_logic_low, fl.low_logic_low,
                  fl.overcurrent, fl.bus_high};
  genvar g;

  // index map, lsb first: bus high, overcurrent, low logic,
  // high logic, then one filter per bootstrap phase
  generate
    for (g = 0; g < NQ; g++) begin : g_len
      if (g == 0) begin : g_ov
        assign q_len[g] = W'(gdp_pkg::OV_FILTER_CYC);
      end else if (g == 1) begin : g_oc
        assign q_len[g] = W'(gdp_pkg::OC_BLANK_CYC);
      end else begin : g_uv
        assign q_len[g] = W'(gdp_pkg::UV_FILTER_CYC);
      end
    end
  endgenerate
  generate
    for (g = 0; g < NQ; g++) begin : g_qual
      logic [W-1:0] cnt_reg;
      always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
          cnt_reg <= '0;
        end else if (!q_raw[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg < q_len[g]) begin
          cnt_reg <= cnt_reg + W'(1);
        end
      end
      assign q_done[g] = q_raw[g] && (cnt_reg >= q_len[g] - W'(1));
    end
  endgenerate

  logic [gdp_pkg::PHASES-1:0] boot_lock;
  logic high_lock;
  logic low_lock;
  logic oc_trip;
  logic ov_trip;
  assign {boot_lock, high_lock, low_lock, oc_trip, ov_trip} = q_done;

  ////////////////////////////////////////////////////////////////////////
  // undervoltage lock states; a lock holds until the flag clears, a bootstrap wait until the next command rising edge
  logic [gdp_pkg::PHASES-1:0] boot_held;
  logic [gdp_pkg::PHASES-1:0] boot_wait;
  logic                       high_lock_reg;
  logic                       low_lock_reg;
  logic [gdp_pkg::PHASES-1:0] hcmd_prev_reg;
  logic [gdp_pkg::PHASES-1:0] hcmd_rise;

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      hcmd_prev_reg <= '0;
    end else begin
      hcmd_prev_reg <= hcmd;
    end
  end

  assign hcmd_rise = hcmd & ~hcmd_prev_reg;

  // recovery is the flag dropping; the comparator owns the hysteresis
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      high_lock_reg <= 1'b0;
    end else begin
      high_lock_reg <= high_lock | (high_lock_reg & fl.high_logic_low);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      low_lock_reg <= 1'b0;
    end else begin
      low_lock_reg <= low_lock | (low_lock_reg & fl.low_logic_low);
    end
  end

  generate
    for (g = 0; g < gdp_pkg::PHASES; g++) begin : g_boot
      logic held_reg;
      logic wait_reg;
      always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
          held_reg <= 1'b0;
          wait_reg <= 1'b0;
        end else if (boot_lock[g]) begin
          held_reg <= 1'b1;
          wait_reg <= 1'b1;
        end else begin
          if (!fl.bootstrap_low[g]) begin
            held_reg <= 1'b0;
          end
          // a command left high through the lock must not restart the gate
          if (!held_reg && hcmd_rise[g]) begin
            wait_reg <= 1'b0;
          end
        end
      end
      assign boot_held[g] = held_reg;
      assign boot_wait[g] = wait_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // overcurrent and overvoltage hold timers
  // set wins: a trip inside a running hold restarts it from zero
  // the long hold needs 21 of the 24 counter bits; a CNT_W below 21
  // would silently shorten it
  logic [W-1:0] oc_cnt_reg;
  logic         oc_hold_reg;
  logic [W-1:0] oc_len;
  assign oc_len = sel_long ? W'(OC_HOLD_LONG) : W'(gdp_pkg::OC_HOLD_SHORT_CYC);

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      oc_cnt_reg  <= '0;
      oc_hold_reg <= 1'b0;
    end else if (oc_trip) begin
      oc_cnt_reg  <= '0;
      oc_hold_reg <= 1'b1;
    end else if (oc_hold_reg) begin
      if (oc_cnt_reg >= oc_len - W'(1)) begin
        oc_hold_reg <= 1'b0;
      end else begin
        oc_cnt_reg <= oc_cnt_reg + W'(1);
      end
    end
  end

  logic [W-1:0] ov_cnt_reg;
  logic         ov_hold_reg;
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ov_cnt_reg  <= '0;
      ov_hold_reg <= 1'b0;
    end else if (ov_trip) begin
      ov_cnt_reg  <= '0;
      ov_hold_reg <= 1'b1;
    end else if (ov_hold_reg) begin
      if (!fl.bus_released) begin
        ov_cnt_reg <= '0; // count only once the bus is at or below release
      end else if (ov_cnt_reg >= W'(gdp_pkg::OV_HOLD_CYC) - W'(1)) begin
        ov_hold_reg <= 1'b0;
      end else begin
        ov_cnt_reg <= ov_cnt_reg + W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault line drive and gate outputs
  logic                       fault_drive;
  logic                       low_cause;
  logic                       oc_cause;
  logic                       ov_cause;
  logic [gdp_pkg::PHASES-1:0] hs_allow;

  // a trip counts in the cycle it qualifies, one ahead of its hold flop
  assign low_cause = low_lock | low_lock_reg;
  assign oc_cause  = oc_trip | oc_hold_reg;
  assign ov_cause  = ov_trip | ov_hold_reg;
  // high-side lockouts deliberately left out of the fault drive
  assign fault_drive = low_cause | oc_cause | ov_cause;

  generate
    for (g = 0; g < gdp_pkg::PHASES; g++) begin : g_gate
      assign hs_allow[g] = ~high_lock & ~high_lock_reg & ~boot_lock[g]
                           & ~boot_held[g] & ~boot_wait[g];
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      FAULT_LINE_OUT <= 1'b0;
      FAULT_LINE_OE  <= 1'b0;
    end else begin
      FAULT_LINE_OUT <= 1'b0;
      FAULT_LINE_OE  <= fault_drive;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      HIGH_SIDE_GATE_OUT <= '0;
      LOW_SIDE_GATE_OUT  <= '0;
    end else begin
      HIGH_SIDE_GATE_OUT <= hcmd & hs_allow;
      // sensed low covers own drive and external shutdown
      LOW_SIDE_GATE_OUT <= (fault_drive | line_low) ? '0 : lcmd;
    end
  end

endmodule
`default_nettype wire

// ==== gdp_properties.sv ====
/* checker for gdp_protect: timing of locks, trips and fault drive at the ports.
   assumes comparator flags stay steady for whole test phases. */
`timescale 1ns/10ps
`default_nettype none
module gdp_properties (
  input wire logic                       CLOCK,
  input wire logic                       RSTN,
  input wire logic [gdp_pkg::PHASES-1:0] HIGH_SIDE_COMMAND,
  input wire logic [gdp_pkg::PHASES-1:0] LOW_SIDE_COMMAND,
  input wire gdp_pkg::gdp_flags_s        FLAGS,
  input wire logic                       HOLD_SELECT_LONG,
  input wire logic                       FAULT_LINE_IN,
  input wire logic                       FAULT_LINE_OUT,
  input wire logic                       FAULT_LINE_OE,
  input wire logic [gdp_pkg::PHASES-1:0] HIGH_SIDE_GATE_OUT,
  input wire logic [gdp_pkg::PHASES-1:0] LOW_SIDE_GATE_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  logic [15:0] c_bs, c_hl, c_ll, c_oc, c_ov;
  ////////////////////////////////////////
  // run lengths; margins cover the two sync stages
  always_ff @(posedge CLOCK) begin
    c_bs <= (RSTN && FLAGS.bootstrap_low[0]) ? c_bs + 16'h1 : 16'h0;
    c_hl <= (RSTN && FLAGS.high_logic_low) ? c_hl + 16'h1 : 16'h0;
    c_ll <= (RSTN && FLAGS.low_logic_low) ? c_ll + 16'h1 : 16'h0;
    c_oc <= (RSTN && FLAGS.overcurrent) ? c_oc + 16'h1 : 16'h0;
    c_ov <= (RSTN && FLAGS.bus_high) ? c_ov + 16'h1 : 16'h0;
  end
  ////////////////////////////////////////
  fault_data_zero_a: assert property (FAULT_LINE_OUT == 1'b0) else $error("fault data high");
  oe_low_off_a: assert property (FAULT_LINE_OE |-> LOW_SIDE_GATE_OUT == 3'h0)
    else $error("low gate on while pulling");
  line_low_off_a: assert property (!FAULT_LINE_IN [*6] |-> LOW_SIDE_GATE_OUT == 3'h0)
    else $error("low gate on while line low");
  boot_lock_a: assert property (c_bs > 16'd760 |-> !HIGH_SIDE_GATE_OUT[0]) else $error("no boot lock");
  hs_lock_a: assert property (c_hl > 16'd760 |-> HIGH_SIDE_GATE_OUT == 3'h0) else $error("no hs lock");
  ls_lock_a: assert property (c_ll > 16'd760 |-> FAULT_LINE_OE && LOW_SIDE_GATE_OUT == 3'h0)
    else $error("no ls lock");
  oc_trip_a: assert property (c_oc > 16'd130 |-> FAULT_LINE_OE) else $error("no oc trip");
  ov_trip_a: assert property (c_ov > 16'd505 |-> FAULT_LINE_OE) else $error("no ov trip");
  oe_cause_a: assert property ($rose(FAULT_LINE_OE) |-> c_oc > 16'd120 || c_ov > 16'd495 || c_ll > 16'd745)
    else $error("pull without cause");
  cover property ($rose(FAULT_LINE_OE));
  cover property ($fell(FAULT_LINE_OE));
  cover property ($rose(HIGH_SIDE_GATE_OUT[0]));
endmodule
bind gdp_protect gdp_properties chk (.CLOCK(CLOCK), .RSTN(RSTN), .FLAGS(FLAGS),
  .HIGH_SIDE_COMMAND(HIGH_SIDE_COMMAND), .LOW_SIDE_COMMAND(LOW_SIDE_COMMAND),
  .HOLD_SELECT_LONG(HOLD_SELECT_LONG), .FAULT_LINE_IN(FAULT_LINE_IN),
  .FAULT_LINE_OUT(FAULT_LINE_OUT), .FAULT_LINE_OE(FAULT_LINE_OE),
  .HIGH_SIDE_GATE_OUT(HIGH_SIDE_GATE_OUT), .LOW_SIDE_GATE_OUT(LOW_SIDE_GATE_OUT));
`default_nettype wire

// ==== gdp_controller.sv ====
/* motor controller model: drives commands, stops on a fault, sends shutdown pulses.
   assumes a pulled-up fault wire; restart delay shortened for simulation. */
`timescale 1ns/10ps
`default_nettype none
module gdp_controller #(parameter int RESTART_CYC = 40) (
  input  wire logic       clock,
  input  wire logic       fault_line,
  input  wire logic       shut_req,
  input  wire logic [2:0] hi_pat,
  input  wire logic [2:0] lo_pat,
  output logic [2:0]      hi_cmd,
  output logic [2:0]      lo_cmd,
  output logic            pull_low
);
  int quiet = 0;
  int pull_cnt = 0;
  always_ff @(posedge clock) begin
    if (shut_req) pull_cnt <= gdp_pkg::SD_MIN_PULSE_CYC;
    else if (pull_cnt > 0) pull_cnt <= pull_cnt - 1;
  end
  assign pull_low = pull_cnt > 0;
  // own shutdown is no fault; any other low stops the motor at once
  always_ff @(posedge clock) begin
    if (!fault_line && !pull_low) quiet <= 0;
    else if (quiet < RESTART_CYC) quiet <= quiet + 1;
  end
  assign hi_cmd = (quiet < RESTART_CYC) ? 3'h0 : hi_pat;
  assign lo_cmd = (quiet < RESTART_CYC) ? 3'h0 : lo_pat;
endmodule
`default_nettype wire

// ==== gdp_protect_bench.sv ====
/* bench for gdp_protect: scenario tasks against the controller model.
   assumes the long hold is shortened through OC_HOLD_LONG. */
`timescale 1ns/10ps
`default_nettype none
module gdp_protect_bench;
  localparam int LONG = 3000;
  logic clock = 0, rstn = 0, sel = 0, shut = 0, oe, fo, fault_line;
  logic [2:0] hi_pat = 3'h5, lo_pat = 3'h3, hc, lc, hi, lo;
  logic pull;
  gdp_pkg::gdp_flags_s flags = 9'h001;
  int n_errors = 0, checks = 0, cyc = 0;
  assign fault_line = !(oe | pull);
  gdp_protect #(.OC_HOLD_LONG(LONG)) DUT (.CLOCK(clock), .RSTN(rstn),
    .HIGH_SIDE_COMMAND(hc), .LOW_SIDE_COMMAND(lc), .FLAGS(flags), .HOLD_SELECT_LONG(sel),
    .FAULT_LINE_IN(fault_line), .FAULT_LINE_OUT(fo), .FAULT_LINE_OE(oe),
    .HIGH_SIDE_GATE_OUT(hi), .LOW_SIDE_GATE_OUT(lo));
  gdp_controller ctl (.clock(clock), .fault_line(fault_line), .shut_req(shut),
    .hi_pat(hi_pat), .lo_pat(lo_pat), .hi_cmd(hc), .lo_cmd(lc), .pull_low(pull));
  initial forever #2 clock = !clock;
  ////////////////////////////////////////
  task automatic step(int n); repeat (n) @(posedge clock); #1; endtask
  task automatic chk(string what, logic [2:0] seen, logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) if (++cyc == 60000) begin n_errors++; tally_and_finish(); end
  ////////////////////////////////////////
  task automatic t_boot;
    repeat (2) begin flags.bootstrap_low[0] = 1; step(700); flags.bootstrap_low[0] = 0; step(3); end
    chk("boot glitch", hi, 3'h5);
    flags.bootstrap_low[0] = 1; step(800);
    chk("boot lock", hi, 3'h4);
    chk("boot oe", oe, 0);
    flags.bootstrap_low[0] = 0; step(20);
    chk("boot wait edge", hi, 3'h4);
    hi_pat = 3'h4; step(5); hi_pat = 3'h5; step(5);
    chk("boot edge", hi, 3'h5);
    $display("test boot done");
  endtask
  task automatic t_logic;
    flags.high_logic_low = 1; step(800);
    chk("hs lock", hi, 3'h0);
    chk("hs oe", oe, 0);
    flags.high_logic_low = 0; step(5);
    chk("hs back", hi, 3'h5);
    flags.low_logic_low = 1; step(800);
    chk("ls lock", lo, 3'h0);
    chk("ls line", fault_line, 0);
    flags.low_logic_low = 0; step(60);
    chk("ls back", lo, 3'h3);
    $display("test logic done");
  endtask
  task automatic t_oc(logic s, int hold);
    sel = s; flags.overcurrent = 1; step(100); flags.overcurrent = 0; step(5);
    chk("oc short", oe, 0);
    flags.overcurrent = 1; step(130);
    chk("oc oe", oe, 1);
    chk("oc low", lo, 3'h0);
    flags.overcurrent = 0; step(hold - 150);
    chk("oc held", oe, 1);
    step(300);
    chk("oc end", oe, 0);
    step(60);
    chk("oc back", lo, 3'h3);
    $display("test oc done");
  endtask
  task automatic t_ov;
    flags.bus_released = 0; flags.bus_high = 1; step(450);
    chk("ov early", oe, 0);
    step(100);
    chk("ov oe", oe, 1);
    chk("ov low", lo, 3'h0);
    flags.bus_high = 0; flags.bus_released = 1; step(gdp_pkg::OV_HOLD_CYC - 150);
    chk("ov held", oe, 1);
    step(300);
    chk("ov end", oe, 0);
    $display("test ov done");
  endtask
  task automatic t_shut;
    step(60); shut = 1; step(1); shut = 0; step(300);
    chk("sd low", lo, 3'h0);
    chk("sd no pull", oe, 0);
    chk("fo zero", fo, 0);
    chk("sd high on", hi, 3'h5);
    step(500);
    chk("sd back", lo, 3'h3);
    $display("test shut done");
  endtask
  initial begin
    step(3); rstn = 1; step(60);
    chk("follow hs", hi, 3'h5);
    chk("follow ls", lo, 3'h3);
    t_boot(); t_logic(); t_oc(0, gdp_pkg::OC_HOLD_SHORT_CYC); t_oc(1, LONG); t_ov(); t_shut();
    tally_and_finish();
  end
endmodule
`default_nettype wire
